// ---- design/afe_irq_mid_defines.svh ----
// Offsets, field positions, reset values and widths for the status-flag slice
`ifndef AFE_IRQ_MID_DEFINES_SVH
`define AFE_IRQ_MID_DEFINES_SVH

`define ADDR_STATUS          4'h0
`define ADDR_CLEAR           4'h1
`define ADDR_CHANGE_THRESH   4'h2
`define ADDR_UPPER_LIMIT     4'h3
`define ADDR_TRIGGER         4'h4

`define BIT_BOOT_DONE        13
`define BIT_USER_EVENT3      12
`define BIT_USER_EVENT0      9
`define BIT_MEAN             7
`define BIT_CHANGE_FAIL      6
`define BIT_UPPER_FAIL       5

`define CHANGE_THRESH_RST    16'h0000
`define UPPER_LIMIT_RST      16'hFFFF
`define RESULT_W             16

`endif

// ---- design/afe_irq_mid_pkg.sv ----
// Types shared by the status-flag slice
package afe_irq_mid_pkg;
    typedef struct packed {
        logic        boot_load_done_flag;
        logic [3:0]  user_event_flag;
        logic        mean_result_flag;
        logic        result_change_fail_flag;
        logic        result_upper_fail_flag;
    } flag_set_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } adc_result_t;
endpackage

// ---- design/afe_irq_status_flags_mid.sv ----
// Middle slice of the front-end interrupt status word, with limit checks
`timescale 1ns/1ps
`include "afe_irq_mid_defines.svh"

module afe_irq_status_flags_mid
    import afe_irq_mid_pkg::*;
#(
    parameter int RW = `RESULT_W
) (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic [3:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic [31:0]            rdata,
    input  wire adc_result_t       adc_result,
    input  wire logic              boot_done_evt,
    input  wire logic              mean_evt,
    input  wire logic              seq_wr_en,
    input  wire logic [3:0]        seq_wdata,
    output flag_set_t              flags
);

    flag_set_t        flags_nxt;
    logic [RW-1:0]    change_thresh_r, change_thresh_nxt;
    logic [RW-1:0]    upper_limit_r,   upper_limit_nxt;
    logic [RW-1:0]    prev_result_r,   prev_result_nxt;
    logic             prev_valid_r,    prev_valid_nxt;
    logic [31:0]      rdata_nxt;
    logic [13:5]      status_word;
    logic             change_hit;
    logic             upper_hit;
    logic [3:0]       user_set;
    flag_set_t        clr;

    function automatic logic [RW-1:0] abs_diff(input logic [RW-1:0] a, input logic [RW-1:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    function automatic logic [13:5] pack_status(input flag_set_t f);
        pack_status = {f.boot_load_done_flag, f.user_event_flag, 1'b0, f.mean_result_flag,
                       f.result_change_fail_flag, f.result_upper_fail_flag};
    endfunction

    always_comb begin
        status_word = pack_status(flags);
        change_hit  = adc_result.valid && prev_valid_r
                      && (abs_diff(adc_result.data[RW-1:0], prev_result_r) > change_thresh_r);
        upper_hit   = adc_result.valid && (adc_result.data[RW-1:0] > upper_limit_r);
        user_set    = seq_wr_en ? seq_wdata : 4'h0;
        clr         = '0;
        if (wr_en && addr == `ADDR_CLEAR) begin
            clr.boot_load_done_flag     = wdata[`BIT_BOOT_DONE];
            clr.user_event_flag         = wdata[`BIT_USER_EVENT3:`BIT_USER_EVENT0];
            clr.mean_result_flag        = wdata[`BIT_MEAN];
            clr.result_change_fail_flag = wdata[`BIT_CHANGE_FAIL];
            clr.result_upper_fail_flag  = wdata[`BIT_UPPER_FAIL];
        end
        // Set beats a clear arriving in the same cycle
        flags_nxt.boot_load_done_flag     = boot_done_evt
                                            | (flags.boot_load_done_flag & ~clr.boot_load_done_flag);
        flags_nxt.user_event_flag         = user_set | (flags.user_event_flag & ~clr.user_event_flag);
        flags_nxt.mean_result_flag        = mean_evt | (flags.mean_result_flag & ~clr.mean_result_flag);
        flags_nxt.result_change_fail_flag = change_hit
                                            | (flags.result_change_fail_flag & ~clr.result_change_fail_flag);
        flags_nxt.result_upper_fail_flag  = upper_hit
                                            | (flags.result_upper_fail_flag & ~clr.result_upper_fail_flag);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flags <= '0;
        end else begin
            flags <= flags_nxt;
        end
    end

    // Previous result memory and the two limit registers
    always_comb begin
        prev_valid_nxt    = prev_valid_r | adc_result.valid;
        prev_result_nxt   = adc_result.valid ? adc_result.data[RW-1:0] : prev_result_r;
        change_thresh_nxt = change_thresh_r;
        upper_limit_nxt   = upper_limit_r;
        if (wr_en && addr == `ADDR_CHANGE_THRESH) begin
            change_thresh_nxt = wdata[RW-1:0];
        end
        if (wr_en && addr == `ADDR_UPPER_LIMIT) begin
            upper_limit_nxt = wdata[RW-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            change_thresh_r <= RW'(`CHANGE_THRESH_RST);
            upper_limit_r   <= RW'(`UPPER_LIMIT_RST);
            prev_result_r   <= '0;
            prev_valid_r    <= 1'b0;
        end else begin
            change_thresh_r <= change_thresh_nxt;
            upper_limit_r   <= upper_limit_nxt;
            prev_result_r   <= prev_result_nxt;
            prev_valid_r    <= prev_valid_nxt;
        end
    end

    // Read port: data stand for one cycle, then fall back to zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                `ADDR_STATUS:        rdata_nxt = {18'h0, status_word, 5'h0};
                `ADDR_CHANGE_THRESH: rdata_nxt = {{(32-RW){1'b0}}, change_thresh_r};
                `ADDR_UPPER_LIMIT:   rdata_nxt = {{(32-RW){1'b0}}, upper_limit_r};
                `ADDR_TRIGGER:       rdata_nxt = {28'h0, flags.user_event_flag};
                default:             rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    sequence s_boot_evt;
        boot_done_evt;
    endsequence

    property p_boot_sets;
        @(posedge core_clk) disable iff (!nrst) s_boot_evt |=> flags.boot_load_done_flag;
    endproperty
    a_boot_sets: assert property (p_boot_sets) else $error("boot flag not set");

    property p_user_sets;
        @(posedge core_clk) disable iff (!nrst)
            seq_wr_en |=> ((flags.user_event_flag & $past(seq_wdata)) == $past(seq_wdata));
    endproperty
    a_user_sets: assert property (p_user_sets) else $error("user flag not set");

    property p_change_sets;
        @(posedge core_clk) disable iff (!nrst) change_hit |=> flags.result_change_fail_flag;
    endproperty
    a_change_sets: assert property (p_change_sets) else $error("change flag not set");

    property p_change_holds;
        @(posedge core_clk) disable iff (!nrst)
            (flags.result_change_fail_flag && !(wr_en && addr == `ADDR_CLEAR && wdata[`BIT_CHANGE_FAIL]))
            |=> flags.result_change_fail_flag;
    endproperty
    a_change_holds: assert property (p_change_holds) else $error("change flag dropped");

    property p_upper_sets;
        @(posedge core_clk) disable iff (!nrst)
            (adc_result.valid && adc_result.data > upper_limit_r) |=> flags.result_upper_fail_flag;
    endproperty
    a_upper_sets: assert property (p_upper_sets) else $error("upper flag not set");

    property p_user_only_seq;
        @(posedge core_clk) disable iff (!nrst)
            (!seq_wr_en) |=> ((flags.user_event_flag & ~$past(flags.user_event_flag)) == 4'h0);
    endproperty
    a_user_only_seq: assert property (p_user_only_seq) else $error("user flag rose without sequencer");

    property p_status_read;
        @(posedge core_clk) disable iff (!nrst)
            (rd_en && addr == `ADDR_STATUS) |=> (rdata[13:5] == $past(status_word));
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read mismatch");

    property p_no_spurious_boot;
        @(posedge core_clk) disable iff (!nrst)
            (!flags.boot_load_done_flag && !boot_done_evt) |=> !flags.boot_load_done_flag;
    endproperty
    a_no_spurious_boot: assert property (p_no_spurious_boot) else $error("boot flag rose alone");

    sequence s_clear_wr;
        wr_en && addr == `ADDR_CLEAR;
    endsequence

    sequence s_read_only_wr;
        wr_en && (addr == `ADDR_STATUS || addr == `ADDR_TRIGGER)
        && !boot_done_evt && !mean_evt && !seq_wr_en && !adc_result.valid;
    endsequence

    property p_user_clear;
        @(posedge core_clk) disable iff (!nrst)
            s_clear_wr |=> ($past(seq_wr_en)
                || ((flags.user_event_flag & $past(wdata[`BIT_USER_EVENT3:`BIT_USER_EVENT0])) == 4'h0));
    endproperty
    a_user_clear: assert property (p_user_clear) else $error("user flag survived clear");

    property p_read_only_wr;
        @(posedge core_clk) disable iff (!nrst)
            s_read_only_wr |=> (flags == $past(flags));
    endproperty
    a_read_only_wr: assert property (p_read_only_wr) else $error("flags moved on read-only write");

    property p_read_idle;
        @(posedge core_clk) disable iff (!nrst)
            (!rd_en) |=> (rdata == 32'h0000_0000);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data held past its cycle");

    property p_upper_holds;
        @(posedge core_clk) disable iff (!nrst)
            (flags.result_upper_fail_flag && !(wr_en && addr == `ADDR_CLEAR && wdata[`BIT_UPPER_FAIL]))
            |=> flags.result_upper_fail_flag;
    endproperty
    a_upper_holds: assert property (p_upper_holds) else $error("upper flag dropped");

    property p_change_quiet;
        @(posedge core_clk) disable iff (!nrst)
            (!flags.result_change_fail_flag && !adc_result.valid) |=> !flags.result_change_fail_flag;
    endproperty
    a_change_quiet: assert property (p_change_quiet) else $error("change flag rose without result");

    property p_upper_quiet;
        @(posedge core_clk) disable iff (!nrst)
            (!flags.result_upper_fail_flag && !adc_result.valid) |=> !flags.result_upper_fail_flag;
    endproperty
    a_upper_quiet: assert property (p_upper_quiet) else $error("upper flag rose without result");

    property p_limit_write;
        @(posedge core_clk) disable iff (!nrst)
            (wr_en && addr == `ADDR_UPPER_LIMIT) |=> (upper_limit_r == $past(wdata[RW-1:0]));
    endproperty
    a_limit_write: assert property (p_limit_write) else $error("upper limit not written");

endmodule

// ---- test/afe_irq_status_flags_mid_bench.sv ----
// Self-checking bench for the middle status-flag slice
`timescale 1ns/1ps
`include "afe_irq_mid_defines.svh"

module afe_irq_status_flags_mid_bench
    import afe_irq_mid_pkg::*;
;
    logic        core_clk      = 1'b0;
    logic        nrst          = 1'b0;
    logic [3:0]  addr          = 4'h0;
    logic [31:0] wdata         = 32'h0;
    logic        wr_en         = 1'b0;
    logic        rd_en         = 1'b0;
    logic [31:0] rdata;
    adc_result_t adc_result    = '0;
    logic        boot_done_evt = 1'b0;
    logic        mean_evt      = 1'b0;
    logic        seq_wr_en     = 1'b0;
    logic [3:0]  seq_wdata     = 4'h0;
    flag_set_t   flags;
    int          errors        = 0;
    int          n_checks      = 0;
    int          cycles        = 0;

    always #12.5 core_clk = ~core_clk;

    afe_irq_status_flags_mid #(.RW(16)) dut (
        .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .adc_result(adc_result), .boot_done_evt(boot_done_evt), .mean_evt(mean_evt),
        .seq_wr_en(seq_wr_en), .seq_wdata(seq_wdata), .flags(flags)
    );

    task summarize;
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t exp %h got %h", $time, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1; addr <= a; wdata <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        rd_en <= 1'b1; addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(exp, rdata);
    endtask

    task evt(input logic b, input logic m, input logic s, input logic [3:0] sd);
        @(posedge core_clk);
        boot_done_evt <= b; mean_evt <= m; seq_wr_en <= s; seq_wdata <= sd;
        @(posedge core_clk);
        boot_done_evt <= 1'b0; mean_evt <= 1'b0; seq_wr_en <= 1'b0; seq_wdata <= 4'h0;
    endtask

    task adc(input logic [15:0] d);
        @(posedge core_clk);
        adc_result <= '{valid: 1'b1, data: d};
        @(posedge core_clk);
        adc_result <= '{valid: 1'b0, data: d};
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`ADDR_STATUS, 32'h0);
        chk(32'h0, {24'h0, flags});
        rd(`ADDR_CHANGE_THRESH, 32'h0000);
        rd(`ADDR_UPPER_LIMIT, 32'h0000FFFF);
        rd(4'hF, 32'h0);
        evt(1'b1, 1'b1, 1'b1, 4'hA);
        rd(`ADDR_STATUS, 32'h00003480);
        @(posedge core_clk);
        #1 chk(32'h0, rdata);
        chk(32'h000000D4, {24'h0, flags});
        rd(`ADDR_TRIGGER, 32'h0000000A);
        wr(`ADDR_STATUS, 32'hFFFFFFFF);
        wr(`ADDR_TRIGGER, 32'hFFFFFFFF);
        rd(`ADDR_STATUS, 32'h00003480);
        evt(1'b0, 1'b0, 1'b1, 4'h5);
        rd(`ADDR_STATUS, 32'h00003E80);
        wr(`ADDR_CLEAR, 32'h00003EE0);
        rd(`ADDR_STATUS, 32'h0);
        fork
            wr(`ADDR_CLEAR, 32'h00002000);
            evt(1'b1, 1'b0, 1'b0, 4'h0);
        join
        rd(`ADDR_STATUS, 32'h00002000);
        wr(`ADDR_CLEAR, 32'h00002000);
        rd(`ADDR_STATUS, 32'h0);
        wr(`ADDR_CHANGE_THRESH, 32'h20);
        rd(`ADDR_CHANGE_THRESH, 32'h20);
        adc(16'h0010);
        adc(16'h0030);
        rd(`ADDR_STATUS, 32'h0);
        adc(16'h0051);
        rd(`ADDR_STATUS, 32'h00000040);
        adc(16'h0051);
        repeat (4) @(posedge core_clk);
        rd(`ADDR_STATUS, 32'h00000040);
        wr(`ADDR_CLEAR, 32'h00000040);
        rd(`ADDR_STATUS, 32'h0);
        adc(16'h0030);
        rd(`ADDR_STATUS, 32'h00000040);
        wr(`ADDR_CLEAR, 32'h00003EE0);
        wr(`ADDR_CHANGE_THRESH, 32'hFFFF);
        wr(`ADDR_UPPER_LIMIT, 32'h100);
        rd(`ADDR_UPPER_LIMIT, 32'h100);
        adc(16'h0100);
        rd(`ADDR_STATUS, 32'h0);
        adc(16'h0101);
        rd(`ADDR_STATUS, 32'h00000020);
        chk(32'h00000001, {24'h0, flags});
        summarize();
    end
endmodule
